// File: rtl/ulms_pkg.sv
// package: register map, field positions and reset values of the status block
package ulms_pkg;

	// ----------------------------------------
	// register byte offsets
	// ----------------------------------------
	localparam logic [7:0] OFS_LINE_STATUS = 8'h00;
	localparam logic [7:0] OFS_MODEM_STATUS = 8'h04;
	localparam logic [7:0] OFS_MODEM_CONTROL = 8'h08;
	localparam logic [7:0] OFS_FIFO_CONTROL = 8'h0c;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
	localparam logic [7:0] OFS_RX_DATA = 8'h18;

	// ----------------------------------------
	// line status fields
	// ----------------------------------------
	localparam int unsigned LS_READY = 0;
	localparam int unsigned LS_OVERRUN = 1;
	localparam int unsigned LS_PARITY = 2;

	// ----------------------------------------
	// modem control fields
	// ----------------------------------------
	localparam int unsigned MC_DTR = 0;
	localparam int unsigned MC_RTS = 1;
	localparam int unsigned MC_USER_ONE = 2;
	localparam int unsigned MC_USER_TWO = 3;
	localparam int unsigned MC_LOOP = 4;
	localparam int unsigned MC_W = 5;

	// ----------------------------------------
	// modem line index (modem_status low nibble)
	// ----------------------------------------
	localparam int unsigned ML_CTS = 0;
	localparam int unsigned ML_DSR = 1;
	localparam int unsigned ML_RI = 2;
	localparam int unsigned ML_CD = 3;

	// ----------------------------------------
	// interrupt status / mask fields
	// ----------------------------------------
	localparam int unsigned IRQ_MODEM = 0;
	localparam int unsigned IRQ_OVERRUN = 1;
	localparam int unsigned IRQ_PARITY = 2;
	localparam int unsigned IRQ_RX_DATA = 3;
	localparam int unsigned IRQ_W = 4;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [4:0] MODEM_CONTROL_RST = 5'h00;
	localparam logic FIFO_ENABLE_RST = 1'b0;
	localparam logic [3:0] IRQ_MASK_RST = 4'h0;
	localparam logic [3:0] PIN_IDLE_RST = 4'hf;
	localparam int unsigned RX_FIFO_DEPTH = 32;

endpackage

// File: rtl/ulms_top.sv
// module: line status and modem status logic of one serial channel, apb slave
`timescale 1ns/1ps
`default_nettype none
// How it works
// R01: parity error bit set for bad parity
// R02: fifo mode reports parity of head entry
// R03: overrun set when arrival meets full fifo
// R04: overrun overwrites receive shift register
// R05: overrunning byte never enters the fifo
// R06: data ready high while characters wait
// R07: data ready low when nothing waits
// R08: change bit set on modem input change
// R09: modem status read clears change bits
// R10: bit 7 carrier, loopback user output two
// R11: bit 6 ring, loopback user output one
// R12: bit 5 dsr, loopback dtr control
// R13: bit 4 cts, loopback rts control
// R14: change bits 3,1,0 catch both directions
// R15: ring change only on pin rising
// R16: modem interrupt while any change bit set
// R17: modem inputs synchronised before edge detection
module ulms_top #(
	parameter int unsigned DEPTH = ulms_pkg::RX_FIFO_DEPTH
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic resetn_i,
	// apb slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// receiver character strobe
	input wire logic rx_valid_i,
	input wire logic [7:0] rx_char_i,
	input wire logic rx_parity_err_i,
	// modem pins, active low
	input wire logic cd_n_i,
	input wire logic ri_n_i,
	input wire logic dsr_n_i,
	input wire logic cts_n_i,
	output logic dtr_n_o,
	output logic rts_n_o,
	output logic user_output_one_n_o,
	output logic user_output_two_n_o,
	// interrupts
	output logic irq_o,
	output logic modem_irq_o
);
	import ulms_pkg::*;

	localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int unsigned CW = $clog2(DEPTH + 1);

	function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
		if (p == PW'(DEPTH - 1)) begin
			return '0;
		end
		return p + PW'(1);
	endfunction

	// ----------------------------------------
	// apb decode
	// ----------------------------------------
	logic setup_rd;
	logic access;
	logic mapped;
	logic wr_en;
	logic rd_done;

	assign setup_rd = psel_i & ~penable_i & ~pwrite_i;
	assign access = psel_i & penable_i;
	assign pready_o = 1'b1;

	always_comb begin
		case (paddr_i)
			OFS_LINE_STATUS, OFS_MODEM_STATUS, OFS_MODEM_CONTROL, OFS_FIFO_CONTROL,
			OFS_IRQ_STATUS, OFS_IRQ_MASK, OFS_RX_DATA: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end

	assign pslverr_o = access & ~mapped;
	assign wr_en = access & pwrite_i & mapped;
	assign rd_done = access & ~pwrite_i;

	// ----------------------------------------
	// control registers
	// ----------------------------------------
	logic [MC_W-1:0] modem_control;
	logic fifo_en;
	logic fifo_flush;
	logic [IRQ_W-1:0] irq_mask;

	assign fifo_flush = wr_en && (paddr_i == OFS_FIFO_CONTROL) && (pwdata_i[0] != fifo_en);

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			modem_control <= MODEM_CONTROL_RST;
		end else if (wr_en && paddr_i == OFS_MODEM_CONTROL) begin
			modem_control <= pwdata_i[MC_W-1:0];
		end
	end

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			fifo_en <= FIFO_ENABLE_RST;
		end else if (wr_en && paddr_i == OFS_FIFO_CONTROL) begin
			fifo_en <= pwdata_i[0];
		end
	end

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			irq_mask <= IRQ_MASK_RST;
		end else if (wr_en && paddr_i == OFS_IRQ_MASK) begin
			irq_mask <= pwdata_i[IRQ_W-1:0];
		end
	end

	// ----------------------------------------
	// receive shift register and fifo
	// ----------------------------------------
	logic [8:0] mem [DEPTH];
	logic [PW-1:0] wr_ptr;
	logic [PW-1:0] rd_ptr;
	logic [CW-1:0] count;
	logic [CW-1:0] capacity;
	logic full;
	logic [8:0] shift_reg;
	logic shift_pending;
	logic push;
	logic pop;
	logic overrun_evt;
	logic data_ready;
	logic parity_head;

	// holding register mode holds a single character
	assign capacity = fifo_en ? CW'(DEPTH) : CW'(1);
	assign full = (count >= capacity);
	assign overrun_evt = rx_valid_i & full; // [R03]
	assign push = shift_pending & ~full & ~fifo_flush; // [R05]
	assign data_ready = (count != '0); // [R06] [R07]
	assign pop = rd_done && (paddr_i == OFS_RX_DATA) && data_ready;
	assign parity_head = data_ready ? mem[rd_ptr][8] : 1'b0; // [R01] [R02]

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			shift_reg <= '0;
		end else if (rx_valid_i) begin
			shift_reg <= {rx_parity_err_i, rx_char_i}; // [R04]
		end
	end

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			shift_pending <= 1'b0;
		end else if (rx_valid_i) begin
			shift_pending <= ~full; // [R05]
		end else if (push || fifo_flush) begin
			shift_pending <= 1'b0;
		end
	end

	always_ff @(posedge clock_i) begin
		if (push) begin
			mem[wr_ptr] <= shift_reg;
		end
	end

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else if (fifo_flush) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wr_ptr <= ptr_inc(wr_ptr);
			end
			if (pop) begin
				rd_ptr <= ptr_inc(rd_ptr);
			end
			count <= count + CW'(push) - CW'(pop);
		end
	end

	// ----------------------------------------
	// modem pin synchroniser
	// ----------------------------------------
	logic [3:0] pins_n;
	logic [3:0] sync1;
	logic [3:0] sync2;
	logic [3:0] sync3;
	logic [3:0] pin_stable;

	assign pins_n = {cd_n_i, ri_n_i, dsr_n_i, cts_n_i};

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sync1 <= PIN_IDLE_RST;
			sync2 <= PIN_IDLE_RST;
			sync3 <= PIN_IDLE_RST;
		end else begin
			sync1 <= pins_n; // [R17]
			sync2 <= sync1;
			sync3 <= sync2;
		end
	end

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pin_stable <= PIN_IDLE_RST;
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (sync2[i] == sync3[i]) begin
					pin_stable[i] <= sync3[i]; // [R17]
				end
			end
		end
	end

	// ----------------------------------------
	// modem status levels and change bits
	// ----------------------------------------
	logic loop_mode;
	logic [3:0] level;
	logic [3:0] prev_level;
	logic [3:0] change_set;
	logic [3:0] change;
	logic [3:0] cap_change;
	logic cap_overrun;
	logic overrun;
	logic modem_read;
	logic line_read;

	assign loop_mode = modem_control[MC_LOOP];

	always_comb begin
		if (loop_mode) begin
			level[ML_CD] = modem_control[MC_USER_TWO]; // [R10]
			level[ML_RI] = modem_control[MC_USER_ONE]; // [R11]
			level[ML_DSR] = modem_control[MC_DTR]; // [R12]
			level[ML_CTS] = modem_control[MC_RTS]; // [R13]
		end else begin
			level = ~pin_stable; // [R10] [R11] [R12] [R13]
		end
	end

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			prev_level <= '0;
		end else begin
			prev_level <= level;
		end
	end

	always_comb begin
		change_set = level ^ prev_level; // [R08] [R14]
		change_set[ML_RI] = prev_level[ML_RI] & ~level[ML_RI]; // [R15]
	end

	assign modem_read = rd_done && (paddr_i == OFS_MODEM_STATUS);
	assign line_read = rd_done && (paddr_i == OFS_LINE_STATUS);

	// only bits that were returned are cleared, new changes win
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			change <= '0;
		end else if (modem_read) begin
			change <= (change & ~cap_change) | change_set; // [R09] [R08]
		end else begin
			change <= change | change_set; // [R08]
		end
	end

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			overrun <= 1'b0;
		end else if (overrun_evt) begin
			overrun <= 1'b1; // [R03]
		end else if (line_read && cap_overrun) begin
			overrun <= 1'b0;
		end
	end

	assign modem_irq_o = |change; // [R16]

	// ----------------------------------------
	// interrupt status
	// ----------------------------------------
	logic [IRQ_W-1:0] irq_status;
	logic [IRQ_W-1:0] irq_events;
	logic [IRQ_W-1:0] irq_clear;

	always_comb begin
		irq_events = '0;
		irq_events[IRQ_MODEM] = |(change_set & ~change);
		irq_events[IRQ_OVERRUN] = overrun_evt;
		irq_events[IRQ_PARITY] = push & shift_reg[8];
		irq_events[IRQ_RX_DATA] = push;
	end

	assign irq_clear = (wr_en && paddr_i == OFS_IRQ_STATUS) ? pwdata_i[IRQ_W-1:0] : '0;

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			irq_status <= '0;
		end else begin
			irq_status <= (irq_status & ~irq_clear) | irq_events;
		end
	end

	assign irq_o = |(irq_status & irq_mask);

	// ----------------------------------------
	// read data, captured in the setup cycle
	// ----------------------------------------
	logic [31:0] read_mux;

	always_comb begin
		read_mux = '0;
		case (paddr_i)
			OFS_LINE_STATUS: begin
				read_mux[LS_READY] = data_ready;
				read_mux[LS_OVERRUN] = overrun;
				read_mux[LS_PARITY] = parity_head;
			end
			OFS_MODEM_STATUS: read_mux[7:0] = {level, change};
			OFS_MODEM_CONTROL: read_mux[MC_W-1:0] = modem_control;
			OFS_FIFO_CONTROL: read_mux[0] = fifo_en;
			OFS_IRQ_STATUS: read_mux[IRQ_W-1:0] = irq_status;
			OFS_IRQ_MASK: read_mux[IRQ_W-1:0] = irq_mask;
			OFS_RX_DATA: read_mux[7:0] = data_ready ? mem[rd_ptr][7:0] : 8'h00;
			default: read_mux = '0;
		endcase
	end

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			prdata_o <= '0;
			cap_change <= '0;
			cap_overrun <= 1'b0;
		end else if (setup_rd) begin
			prdata_o <= read_mux;
			cap_change <= change;
			cap_overrun <= overrun;
		end
	end

	// ----------------------------------------
	// modem control pins, parked inactive in loopback
	// ----------------------------------------
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			dtr_n_o <= 1'b1;
			rts_n_o <= 1'b1;
			user_output_one_n_o <= 1'b1;
			user_output_two_n_o <= 1'b1;
		end else begin
			dtr_n_o <= loop_mode | ~modem_control[MC_DTR];
			rts_n_o <= loop_mode | ~modem_control[MC_RTS];
			user_output_one_n_o <= loop_mode | ~modem_control[MC_USER_ONE];
			user_output_two_n_o <= loop_mode | ~modem_control[MC_USER_TWO];
		end
	end

endmodule
`default_nettype wire

// File: verification/ulms_checker.sv
// checker: apb and modem status properties of the status block
`timescale 1ns/1ps
`default_nettype none
module ulms_checker
	import ulms_pkg::*;
(
	// clock and reset
	input wire logic clock_i,
	input wire logic resetn_i,
	// apb
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [31:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o,
	// modem pins and interrupts
	input wire logic cd_n_i,
	input wire logic ri_n_i,
	input wire logic dsr_n_i,
	input wire logic cts_n_i,
	input wire logic dtr_n_o,
	input wire logic rts_n_o,
	input wire logic user_output_one_n_o,
	input wire logic user_output_two_n_o,
	input wire logic irq_o,
	input wire logic modem_irq_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!resetn_i);
	// loopback tracked from control writes, pins are ignored then
	logic loop_on;
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			loop_on <= 1'b0;
		end else if (psel_i && penable_i && pwrite_i && paddr_i == OFS_MODEM_CONTROL) begin
			loop_on <= pwdata_i[MC_LOOP];
		end
	end
	// --------------------------------
	// properties
	// --------------------------------
	sequence s_read_modem;
		psel_i && !penable_i && !pwrite_i && paddr_i == OFS_MODEM_STATUS ##1 psel_i && penable_i;
	endsequence
	property p_unmapped;
		psel_i && penable_i && paddr_i > OFS_RX_DATA |-> pslverr_o && pready_o;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped access not flagged");
	property p_unmapped_read;
		psel_i && penable_i && !pwrite_i && paddr_i > OFS_RX_DATA |-> prdata_o == 32'h0;
	endproperty
	a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");
	property p_reset_quiet;
		$rose(resetn_i) |-> !irq_o && !modem_irq_o;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("interrupt after reset");
	property p_change_seen;
		!loop_on && $changed({cd_n_i, dsr_n_i, cts_n_i}) |-> ##[2:7] modem_irq_o;
	endproperty
	a_change_seen: assert property (p_change_seen) else $error("pin change missed");
	property p_ring_rise;
		!loop_on && $rose(ri_n_i) |-> ##[2:7] modem_irq_o;
	endproperty
	a_ring_rise: assert property (p_ring_rise) else $error("ring change missed");
	property p_read_clear;
		s_read_modem ##0 modem_irq_o |=> ##1 !modem_irq_o;
	endproperty
	a_read_clear: assert property (p_read_clear) else $error("read did not clear");
	property p_irq_match;
		s_read_modem |-> modem_irq_o == (|prdata_o[3:0]);
	endproperty
	a_irq_match: assert property (p_irq_match) else $error("modem irq mismatch");
	property p_ctl_pins;
		psel_i && penable_i && pwrite_i && paddr_i == OFS_MODEM_CONTROL |=> ##1
			{user_output_two_n_o, user_output_one_n_o, rts_n_o, dtr_n_o}
			== ($past(pwdata_i[MC_LOOP], 2) ? 4'hf : ~$past(pwdata_i[3:0], 2));
	endproperty
	a_ctl_pins: assert property (p_ctl_pins) else $error("control pins wrong");
endmodule
bind ulms_top ulms_checker u_checker (.*);
`default_nettype wire

// File: verification/ulms_modem_model.sv
// model: modem side driving the active-low modem status pins
`timescale 1ns/1ps
`default_nettype none
module ulms_modem_model (
	// clock and requested line states
	input wire logic clock_i,
	input wire logic [3:0] active_i,
	// active-low pins towards the device
	output logic cd_n_o,
	output logic ri_n_o,
	output logic dsr_n_o,
	output logic cts_n_o
);
	// pins idle high, change just after an edge
	initial {cd_n_o, ri_n_o, dsr_n_o, cts_n_o} = 4'hf;
	always @(posedge clock_i) begin
		{cd_n_o, ri_n_o, dsr_n_o, cts_n_o} <= ~active_i;
	end
endmodule
`default_nettype wire

// File: verification/ulms_top_test.sv
// testbench: line status, modem status, loopback and interrupt scenarios
`timescale 1ns/1ps
`default_nettype none
module ulms_top_test;
	import ulms_pkg::*;
	logic clock_i, resetn_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, sl;
	logic [7:0] paddr_i, rx_char_i;
	logic [31:0] pwdata_i, prdata_o, rd;
	logic rx_valid_i, rx_parity_err_i, cd_n_i, ri_n_i, dsr_n_i, cts_n_i, irq_o, modem_irq_o;
	logic dtr_n_o, rts_n_o, user_output_one_n_o, user_output_two_n_o;
	logic [3:0] lines;
	int n_errors = 0;
	int tests_run = 0;
	ulms_top u_dut (.*);
	ulms_modem_model u_modem (.clock_i(clock_i), .active_i(lines), .cd_n_o(cd_n_i),
		.ri_n_o(ri_n_i), .dsr_n_o(dsr_n_i), .cts_n_o(cts_n_i));
	// --------------------------------
	// shared tasks
	// --------------------------------
	task automatic wrap_up;
		$display("checks %0d errors %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clock_i);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clock_i);
		penable_i <= 1'b1;
		@(posedge clock_i);
		while (pready_o !== 1'b1) begin
			n++;
			if (n > 16) begin
				n_errors++;
				wrap_up();
			end
			@(posedge clock_i);
		end
		rd = prdata_o;
		sl = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask
	task automatic rdc(input string s, input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(s, e, rd);
	endtask
	task automatic rx(input logic [7:0] c, input logic pe);
		@(posedge clock_i);
		rx_valid_i <= 1'b1;
		rx_char_i <= c;
		rx_parity_err_i <= pe;
		@(posedge clock_i);
		rx_valid_i <= 1'b0;
		repeat (2) @(posedge clock_i);
	endtask
	task automatic pins(input logic [3:0] v);
		@(posedge clock_i);
		lines <= v;
		repeat (8) @(posedge clock_i);
	endtask
	task automatic lp(input logic [7:0] w, input logic [3:0] e);
		bus(1'b1, OFS_MODEM_CONTROL, {24'h0, w});
		repeat (6) @(posedge clock_i);
		bus(1'b0, OFS_MODEM_STATUS, 32'h0);
		chk("loop levels", {28'h0, e}, {28'h0, rd[7:4]});
		chk("control pins", {28'h0, (w[4] ? 4'hf : ~w[3:0])},
			{28'h0, user_output_two_n_o, user_output_one_n_o, rts_n_o, dtr_n_o});
	endtask
	// --------------------------------
	// scenarios
	// --------------------------------
	task automatic t_reset;
		rdc("line_status", OFS_LINE_STATUS, 32'h0);
		rdc("modem_status", OFS_MODEM_STATUS, 32'h0);
		bus(1'b0, 8'h1c, 32'h0);
		chk("unmapped data", 32'h0, rd);
		chk("unmapped error", 32'h1, {31'h0, sl});
		$display("reset test done");
	endtask
	task automatic t_modem;
		pins(4'h1);
		rdc("cts change", OFS_MODEM_STATUS, 32'h11);
		rdc("read clears", OFS_MODEM_STATUS, 32'h10);
		pins(4'h5);
		rdc("ring pin falls", OFS_MODEM_STATUS, 32'h50);
		pins(4'h1);
		rdc("ring pin rises", OFS_MODEM_STATUS, 32'h14);
		pins(4'hb);
		chk("modem irq", 32'h1, {31'h0, modem_irq_o});
		rdc("cd dsr change", OFS_MODEM_STATUS, 32'hba);
		repeat (2) @(posedge clock_i);
		chk("modem irq cleared", 32'h0, {31'h0, modem_irq_o});
		pins(4'h0);
		rdc("all released", OFS_MODEM_STATUS, 32'h0b);
		$display("modem test done");
	endtask
	task automatic t_irq;
		pins(4'h1);
		bus(1'b1, OFS_IRQ_MASK, 32'h1);
		#1 chk("irq unmasked", 32'h1, {31'h0, irq_o});
		bus(1'b1, OFS_IRQ_MASK, 32'h0);
		#1 chk("irq masked", 32'h0, {31'h0, irq_o});
		bus(1'b1, OFS_IRQ_MASK, 32'h1);
		bus(1'b1, OFS_IRQ_STATUS, 32'h1);
		#1 chk("irq cleared", 32'h0, {31'h0, irq_o});
		rdc("cts again", OFS_MODEM_STATUS, 32'h11);
		$display("interrupt test done");
	endtask
	task automatic t_loop;
		lp(8'h1f, 4'hf);
		lp(8'h15, 4'h6);
		lp(8'h1a, 4'h9);
		lp(8'h0a, 4'h1);
		rdc("control readback", OFS_MODEM_CONTROL, 32'h0a);
		$display("loopback test done");
	endtask
	task automatic t_rx;
		int i;
		rx(8'ha5, 1'b1);
		rdc("parity ready", OFS_LINE_STATUS, 32'h05);
		rx(8'h3c, 1'b0);
		rdc("overrun", OFS_LINE_STATUS, 32'h07);
		rdc("held char", OFS_RX_DATA, 32'ha5);
		rdc("empty", OFS_LINE_STATUS, 32'h0);
		bus(1'b1, OFS_FIFO_CONTROL, 32'h1);
		rx(8'h11, 1'b0);
		rx(8'h22, 1'b1);
		rdc("head good", OFS_LINE_STATUS, 32'h01);
		rdc("pop first", OFS_RX_DATA, 32'h11);
		rdc("head bad", OFS_LINE_STATUS, 32'h05);
		rdc("pop second", OFS_RX_DATA, 32'h22);
		rdc("drained", OFS_LINE_STATUS, 32'h0);
		for (i = 0; i < 33; i++) begin
			rx(8'(i), 1'b0);
		end
		rdc("fifo overrun", OFS_LINE_STATUS, 32'h03);
		for (i = 0; i < 32; i++) begin
			rdc("fifo order", OFS_RX_DATA, 32'(i));
		end
		rdc("fifo drained", OFS_LINE_STATUS, 32'h0);
		rdc("fifo control", OFS_FIFO_CONTROL, 32'h1);
		rdc("irq status", OFS_IRQ_STATUS, 32'hf);
		bus(1'b1, OFS_IRQ_STATUS, 32'hf);
		rdc("irq status cleared", OFS_IRQ_STATUS, 32'h0);
		$display("receive test done");
	endtask
	initial begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end
	initial begin
		resetn_i = 1'b0;
		psel_i = 1'b0;
		penable_i = 1'b0;
		pwrite_i = 1'b0;
		paddr_i = 8'h00;
		pwdata_i = 32'h0;
		rx_valid_i = 1'b0;
		rx_char_i = 8'h00;
		rx_parity_err_i = 1'b0;
		lines = 4'h0;
		repeat (2) @(posedge clock_i);
		resetn_i <= 1'b1;
		t_reset();
		t_modem();
		t_irq();
		t_loop();
		t_rx();
		wrap_up();
	end
endmodule
`default_nettype wire
